// [logic/slss_startup_seq.v]
// startup and wake sequencer of the deserializer end of a serial link
// assumes link-detect pins are asynchronous; writes and pixels on mclk
`timescale 1ns/1ns
`include "slss_regs.vh"

module slss_startup_seq #(
  parameter PIX_W = 27,
  parameter BLANK_CYC = `SLSS_BLANK_CYC,
  parameter SLEEP_CYC = `SLSS_SLEEP_CYC,
  parameter LOCK_CYC = `SLSS_LOCK_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire videoSigPin,
  input wire cfgSigPin,
  input wire controlDirectionSelectPin,
  input wire sleepSetWr,
  input wire sleepClrWr,
  input wire [PIX_W-1:0] pixIn,
  input wire pixInValid,
  output wire ctrlChanReady,
  output reg defaultsLoaded_r,
  output wire videoLocked,
  output wire cfgLocked,
  output wire linkClkInternal,
  output reg sleepBit_r,
  output wire asleep,
  output reg ctrlDirLatched_r,
  output reg [PIX_W-1:0] pixOut_r,
  output reg pixOutValid_r
);

// ****************************************************************
// states
// ****************************************************************
localparam ST_LOAD = 3'h0;
localparam ST_SEARCH = 3'h1;
localparam ST_CFGLK = 3'h2;
localparam ST_VIDLK = 3'h3;
localparam ST_SLEEP = 3'h4;

localparam CNT_W = 32;

// ****************************************************************
// pin synchronisers
// ****************************************************************
wire videoSig;
wire cfgSig;
wire ctrlDirSync;

slss_pin_sync #(.RST_VAL(1'b0)) uVideoSync (
  .mclk(mclk),
  .rst_n(rst_n),
  .pinIn(videoSigPin),
  .pinOut(videoSig)
);

slss_pin_sync #(.RST_VAL(1'b0)) uCfgSync (
  .mclk(mclk),
  .rst_n(rst_n),
  .pinIn(cfgSigPin),
  .pinOut(cfgSig)
);

slss_pin_sync #(.RST_VAL(1'b0)) uDirSync (
  .mclk(mclk),
  .rst_n(rst_n),
  .pinIn(controlDirectionSelectPin),
  .pinOut(ctrlDirSync)
);

// ****************************************************************
// registers
// ****************************************************************
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [CNT_W-1:0] blankCnt_r;
reg [CNT_W-1:0] lockCnt_r;
reg [CNT_W-1:0] sleepCnt_r;
reg lockVideo_r; // which signal the lock counter is qualifying
reg wokeRemote_r;
wire blankDone;
wire activity;
wire lockDone;

assign activity = videoSig | cfgSig;
assign blankDone = (blankCnt_r >= BLANK_CYC[CNT_W-1:0]);
assign lockDone = (lockCnt_r >= LOCK_CYC[CNT_W-1:0]);
assign videoLocked = (state_r == ST_VIDLK);
assign cfgLocked = (state_r == ST_CFGLK);
assign asleep = (state_r == ST_SLEEP);
// the internal oscillator clocks the link unless video is locked
assign linkClkInternal = !videoLocked;
// no control traffic before a link locks or inside the blackout
assign ctrlChanReady = blankDone & (videoLocked | cfgLocked);

// power-up blackout timer; the deserializer cannot tell whether the
// serializer came up first, so the blackout is always applied
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
    blankCnt_r <= {CNT_W{1'b0}};
  else if (!blankDone)
    blankCnt_r <= blankCnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
end

// next state
always @*
begin
  state_nxt = state_r;
  case (state_r)
    ST_LOAD:
      state_nxt = ST_SEARCH;
    ST_SEARCH:
      if (lockDone)
        state_nxt = lockVideo_r ? ST_VIDLK : ST_CFGLK;
    ST_CFGLK:
      // video must qualify on its own count; the config count is stale
      if (videoSig && lockVideo_r && lockDone)
        state_nxt = ST_VIDLK;
      else if (!cfgSig && !videoSig)
        state_nxt = ST_SEARCH;
    ST_VIDLK:
      if (!videoSig)
        state_nxt = ST_SEARCH;
    ST_SLEEP:
      if (!sleepBit_r || activity)
        state_nxt = ST_SEARCH;
    default:
      state_nxt = ST_LOAD;
  endcase
  // a pending sleep enters on inactivity or when the timer runs out
  if (sleepBit_r && !wokeRemote_r && state_r != ST_SLEEP &&
      state_r != ST_LOAD &&
      (!activity || sleepCnt_r >= SLEEP_CYC[CNT_W-1:0]))
    state_nxt = ST_SLEEP;
end

// state, lock qualification and sleep timer
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    state_r <= ST_LOAD;
    lockCnt_r <= {CNT_W{1'b0}};
    lockVideo_r <= 1'b0;
    sleepCnt_r <= {CNT_W{1'b0}};
    wokeRemote_r <= 1'b0;
  end
  else
  begin
    state_r <= state_nxt;
    // video takes precedence; a changed choice restarts the count
    if (state_nxt != state_r || !activity ||
        lockVideo_r != videoSig)
      lockCnt_r <= {CNT_W{1'b0}};
    else if (!lockDone)
      lockCnt_r <= lockCnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    lockVideo_r <= videoSig;
    if (!sleepBit_r || state_r == ST_SLEEP)
      sleepCnt_r <= {CNT_W{1'b0}};
    else if (sleepCnt_r < SLEEP_CYC[CNT_W-1:0])
      sleepCnt_r <= sleepCnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    // remember a wake by link activity until the relock clears sleep
    if (state_r == ST_SLEEP && activity && sleepBit_r)
      wokeRemote_r <= 1'b1;
    else if (!sleepBit_r)
      wokeRemote_r <= 1'b0;
  end
end

// sleep bit: software sets and clears; a remote relock clears it.
// a set in the same cycle as any clear wins, but a remote relock clears the bit again on the next cycle
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
    sleepBit_r <= `SLSS_SLEEP_RST;
  else if (sleepSetWr)
    sleepBit_r <= 1'b1;
  else if (sleepClrWr)
    sleepBit_r <= 1'b0;
  else if (wokeRemote_r && (videoLocked || cfgLocked))
    sleepBit_r <= 1'b0;
end

// edge counter after release, saturating; times the strap capture
reg [2:0] dirWait_r;

always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
    dirWait_r <= 3'h0;
  else if (dirWait_r != 3'h7)
    dirWait_r <= dirWait_r + 3'h1;
end

// defaults are in place from the first edge after reset; the direction
// strap is caught once, after its synchroniser has settled, since the
// chain still shows its reset value for the first few edges
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    defaultsLoaded_r <= 1'b0;
    ctrlDirLatched_r <= 1'b0;
  end
  else
  begin
    if (state_r == ST_LOAD)
      defaultsLoaded_r <= 1'b1;
    if (dirWait_r == `SLSS_DIR_WAIT)
      ctrlDirLatched_r <= ctrlDirSync;
  end
end

// ****************************************************************
// parallel video output
// ****************************************************************
// pixels pass only while video is locked; the output holds otherwise
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    pixOut_r <= {PIX_W{`SLSS_PIX_RST}};
    pixOutValid_r <= 1'b0;
  end
  else
  begin
    pixOutValid_r <= videoLocked & pixInValid;
    if (videoLocked && pixInValid)
      pixOut_r <= pixIn;
  end
end

endmodule // slss_startup_seq

// [logic/slss_regs.vh]
// constants shared by the serial link startup sequencer files
// assumes a 50 MHz mclk; times in ns, cycle counts derived below
`ifndef SLSS_REGS_VH
`define SLSS_REGS_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define SLSS_CLK_MHZ 50
// control channel blackout after power-up
`define SLSS_BLANK_NS 2000000
// sleep entry at the latest this long after the sleep bit is set
`define SLSS_SLEEP_NS 8000000
// a link signal must stand this long before it counts as locked
`define SLSS_LOCK_NS 1000
// edges after release before the direction strap is taken; this covers
// the synchroniser latency so the strap is not read as its reset value
`define SLSS_DIR_WAIT 3'h6
// least times round up to whole cycles
`define SLSS_BLANK_CYC ((`SLSS_BLANK_NS * `SLSS_CLK_MHZ + 999) / 1000)
`define SLSS_SLEEP_CYC ((`SLSS_SLEEP_NS * `SLSS_CLK_MHZ + 999) / 1000)
`define SLSS_LOCK_CYC ((`SLSS_LOCK_NS * `SLSS_CLK_MHZ + 999) / 1000)

// ****************************************************************
// reset values
// ****************************************************************
`define SLSS_SLEEP_RST 1'b0
`define SLSS_PIX_RST 1'b0

`endif

// [logic/slss_pin_sync.v]
// three-stage synchroniser for one asynchronous pin
// assumes the pin is a level; output moves when stages two and three agree
`timescale 1ns/1ns

module slss_pin_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire mclk,
  input wire rst_n,
  input wire pinIn,
  output reg pinOut
);

// ****************************************************************
// sampling chain
// ****************************************************************
reg s1_r;
reg s2_r;
reg s3_r;

// first stage feeds only the second, never any logic
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    s1_r <= RST_VAL;
    s2_r <= RST_VAL;
    s3_r <= RST_VAL;
    pinOut <= RST_VAL;
  end
  else
  begin
    s1_r <= pinIn;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (s2_r == s3_r) // a change counts once two stages agree
      pinOut <= s3_r;
  end
end

endmodule // slss_pin_sync

// [test/slss_assertions.sv]
// checker for the startup sequencer, bound to its top ports
// assumes one clock, mclk, and async active-low rst_n
`timescale 1ns/1ns
module slss_assertions #(
  parameter PIX_W = 27,
  parameter BLANK_CYC = 100000
) (
  input wire mclk,
  input wire rst_n,
  input wire videoSigPin,
  input wire sleepClrWr,
  input wire [PIX_W-1:0] pixIn,
  input wire pixInValid,
  input wire ctrlChanReady,
  input wire defaultsLoaded_r,
  input wire videoLocked,
  input wire cfgLocked,
  input wire linkClkInternal,
  input wire sleepBit_r,
  input wire [PIX_W-1:0] pixOut_r,
  input wire pixOutValid_r
);
  int upCnt_r;
  // ****
  // cycles since release, saturating so it cannot wrap
  // ****
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      upCnt_r <= 0;
    else if (upCnt_r < BLANK_CYC)
      upCnt_r <= upCnt_r + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence sWordIn;
    pixInValid && videoLocked;
  endsequence
  sequence sWordOut;
    pixOutValid_r && pixOut_r == $past(pixIn);
  endsequence
  chk_ready_locked: assert property (
    ctrlChanReady |-> videoLocked || cfgLocked) else $error("early ready");
  chk_ready_blank: assert property (
    ctrlChanReady |-> upCnt_r >= BLANK_CYC) else $error("blackout short");
  chk_defaults_up: assert property (
    upCnt_r >= 2 |-> defaultsLoaded_r) else $error("defaults missing");
  chk_video_lock: assert property (
    $rose(videoLocked) |-> videoSigPin) else $error("lock without video");
  chk_pix_pass: assert property (
    sWordIn |=> sWordOut) else $error("word lost");
  chk_pix_drop: assert property (
    !(pixInValid && videoLocked) |=> !pixOutValid_r) else $error("stray");
  chk_wake_clear: assert property (
    $fell(sleepBit_r) && !$past(sleepClrWr) |-> videoLocked || cfgLocked)
    else $error("wake clear unlocked");
  chk_osc_select: assert property (
    !linkClkInternal |-> $past(videoSigPin, 5)) else $error("clock source");
endmodule // slss_assertions

bind slss_startup_seq slss_assertions #(
  .PIX_W(PIX_W),
  .BLANK_CYC(BLANK_CYC)
) chkU (
  .mclk(mclk), .rst_n(rst_n), .videoSigPin(videoSigPin),
  .sleepClrWr(sleepClrWr), .pixIn(pixIn), .pixInValid(pixInValid),
  .ctrlChanReady(ctrlChanReady), .defaultsLoaded_r(defaultsLoaded_r),
  .videoLocked(videoLocked), .cfgLocked(cfgLocked),
  .linkClkInternal(linkClkInternal), .sleepBit_r(sleepBit_r),
  .pixOut_r(pixOut_r), .pixOutValid_r(pixOutValid_r)
);

// [test/slss_far_side.sv]
// model of the remote serializer driving the two link-detect pins
// assumes enables come from the bench acting as the controller
`timescale 1ns/1ns
module slss_far_side #(
  parameter EST_CYC = 6
) (
  input wire mclk,
  input wire serial_link_enable,
  input wire config_link_enable,
  input wire pclkOk,
  output reg videoSig,
  output reg cfgSig
);
  reg [7:0] estCnt_r = 8'h00;
  // ****
  // links need a settling time after both enables drop; a switch between links is instant
  // ****
  always @(posedge mclk)
  begin
    if (!(serial_link_enable || config_link_enable))
      estCnt_r <= 8'h00;
    else if (estCnt_r < EST_CYC)
      estCnt_r <= estCnt_r + 8'h01;
  end
  // video needs a pixel clock; config link only while serial_link_enable is low
  always @*
  begin
    videoSig = serial_link_enable && pclkOk && (estCnt_r == EST_CYC);
    cfgSig = !serial_link_enable && config_link_enable && (estCnt_r == EST_CYC);
  end
endmodule // slss_far_side

// [test/tb_serial_link_startup_sequence.sv]
// bench for the startup sequencer with a far-side serializer model
// assumes short counts: blackout 20, sleep 40, lock 4 cycles
`timescale 1ns/1ns
module tb_serial_link_startup_sequence;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg serial_link_enable = 1'b0;
  reg config_link_enable = 1'b1;
  reg pclkOk = 1'b1;
  reg dirSel = 1'b1;
  reg sleepSet = 1'b0;
  reg sleepClr = 1'b0;
  reg [26:0] pix = 27'h0000000;
  reg pixVal = 1'b0;
  wire vSig, cSig, rdy, dflt, vLock, cLock, intOsc, slp, zz, dir, outVal;
  wire [26:0] outPix;
  wire [4:0] flg = {rdy, !slp, zz, vLock, cLock};
  reg [26:0] expQ[$];
  int errors = 0;
  int check_count = 0;
  int i;
  always #10 mclk = ~mclk;
  slss_far_side farU (.mclk(mclk), .serial_link_enable(serial_link_enable), .config_link_enable(config_link_enable),
    .pclkOk(pclkOk), .videoSig(vSig), .cfgSig(cSig));
  slss_startup_seq #(.BLANK_CYC(20), .SLEEP_CYC(40), .LOCK_CYC(4)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .videoSigPin(vSig), .cfgSigPin(cSig),
    .controlDirectionSelectPin(dirSel), .sleepSetWr(sleepSet),
    .sleepClrWr(sleepClr), .pixIn(pix), .pixInValid(pixVal),
    .ctrlChanReady(rdy), .defaultsLoaded_r(dflt), .videoLocked(vLock),
    .cfgLocked(cLock), .linkClkInternal(intOsc), .sleepBit_r(slp),
    .asleep(zz), .ctrlDirLatched_r(dir), .pixOut_r(outPix),
    .pixOutValid_r(outVal));
  // ****
  // checking and waiting helpers
  // ****
  task chk(input logic ok, input string msg);
  begin
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  end
  endtask
  task close_out;
  begin
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // bounded so a flag that never rises ends the run instead of hanging
  task waitFlag(input int n);
  begin
    i = 0;
    while (flg[n] !== 1'b1 && i < 500)
    begin
      @(negedge mclk);
      i++;
    end
    chk(i < 500, "timeout");
    if (i == 500)
      close_out();
  end
  endtask
  // queue a note only for words the block should deliver
  task sendWords(input int n, input logic keep);
  begin
    repeat (n)
    begin
      pix = 27'($urandom);
      pixVal = 1'b1;
      if (keep)
        expQ.push_back(pix);
      @(negedge mclk);
    end
    pixVal = 1'b0;
  end
  endtask
  // every delivered word must match the oldest note
  always @(negedge mclk)
  begin
    if (outVal === 1'b1)
    begin
      if (expQ.size() == 0)
        chk(1'b0, "unexpected word");
      else
        chk(outPix === expQ.pop_front(), "word");
    end
  end
  initial
  begin
    i = $urandom(40);
    repeat (5) @(negedge mclk);
    chk(intOsc === 1'b1 && rdy === 1'b0, "reset values");
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk(dflt === 1'b1, "defaults");
    waitFlag(0);
    chk(rdy === 1'b0 && intOsc === 1'b1, "blackout");
    chk(dir === 1'b1, "direction strap");
    sendWords(3, 1'b0);
    waitFlag(4);
    chk(cLock === 1'b1, "ready on config link");
    serial_link_enable = 1'b1;
    waitFlag(1);
    chk(intOsc === 1'b0, "video clock");
    sendWords(8, 1'b1);
    repeat (3) @(negedge mclk);
    chk(expQ.size() == 0, "all words out");
    sleepSet = 1'b1;
    @(negedge mclk);
    sleepSet = 1'b0;
    serial_link_enable = 1'b0;
    config_link_enable = 1'b0;
    waitFlag(2);
    // local wake while unlocked: no answer is awaited for the clear
    sleepClr = 1'b1;
    @(negedge mclk);
    sleepClr = 1'b0;
    @(negedge mclk);
    chk(zz === 1'b0 && slp === 1'b0, "local wake");
    sleepSet = 1'b1;
    @(negedge mclk);
    sleepSet = 1'b0;
    waitFlag(2);
    serial_link_enable = 1'b1;
    waitFlag(3);
    chk(vLock === 1'b1, "remote wake");
    // sleep asked for with the link busy falls back on the timer
    sleepSet = 1'b1;
    @(negedge mclk);
    sleepSet = 1'b0;
    waitFlag(2);
    chk(i >= 38 && i <= 44, "sleep timer");
    waitFlag(3);
    chk(vLock === 1'b1, "wake after timer");
    rst_n = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    waitFlag(1);
    chk(rdy === 1'b0 && dir === 1'b1, "blackout after reset");
    close_out();
  end
endmodule // tb_serial_link_startup_sequence
